// [design/lpc_pkg.sv]
// Shared constants and types for the low-power clock stop and wake block
package lpc_pkg;
    localparam int          ADDR_W      = 24;
    localparam int          DATA_W      = 16;
    localparam logic [15:0] SW_RESET    = 16'h2700;
    localparam int          SW_MASK_LSB = 8;
    localparam logic [2:0]  LEVEL_NMI   = 3'h7;
    localparam logic [23:0] BYTE_STEP   = 24'h000001;
    localparam logic [7:0]  LANE_FILL   = 8'h00;

    typedef enum logic [2:0] {
        LPC_IDLE,
        LPC_XFER,
        LPC_SLEEP,
        LPC_WOKEN,
        LPC_RELEASE
    } lpc_state_e;
endpackage

// [design/lpc_arb_if.sv]
// Bus arbitration signals between the clock-stop core and its arbiter
`timescale 1ns/1ps
interface lpc_arb_if;
    logic busRequest;
    logic busIdle;
    logic grant;

    modport arbiter (
        input  busRequest,
        input  busIdle,
        output grant
    );
    modport core (
        output busRequest,
        output busIdle,
        input  grant
    );
endinterface

// [design/lpc_arbiter.sv]
// Two-wire request/grant bus arbiter
`timescale 1ns/1ps
module lpc_arbiter (
    input wire logic clk,
    input wire logic rst_b,
    lpc_arb_if.arbiter arb
);
    logic grant_q;

    // Grant only between bus cycles; request low withdraws it on the next edge
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            grant_q <= 1'b0;
        else if (!arb.busRequest)
            grant_q <= 1'b0;
        else if (arb.busIdle)
            grant_q <= 1'b1;
    end

    assign arb.grant = grant_q;

    chk_grant_idle: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(grant_q) |-> $past(arb.busIdle) && $past(arb.busRequest))
        else $error("grant given during a bus cycle");

    chk_grant_drop: assert property (@(posedge clk) disable iff (!rst_b)
        !arb.busRequest |=> !grant_q)
        else $error("grant held after request withdrawn");
endmodule

// [design/lpc_clock_stop.sv]
// Processor bus, halt-until-interrupt, clock stop and wake control
//
// Behaviour
// - Data width fixed at 8 or 16 bits by a static strap level.
// - In 8-bit width only low lanes carry data; upper lanes driven at the fixed LANE_FILL value.
// - Mastership exchanged with request and grant only, no acknowledge.
// - In 8-bit width the halt operand takes two bus cycles, not one.
// - Low-power lasts until an interrupt above the loaded mask, or at level 7, is recognised.
// - On a resume request the internal clock runs from the next edge.
// - Halt operand loads the status word, whose mask selects the wake level.
`timescale 1ns/1ps
module lpc_clock_stop (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        widthSel16,
    input  wire logic        opReq,
    input  wire logic        opWrite,
    input  wire logic [23:0] opAddr,
    input  wire logic [15:0] opWdata,
    input  wire logic        haltReq,
    output logic             opReady,
    output logic             opDone,
    output logic [15:0]      opRdata,
    output logic [15:0]      statusWord,
    output logic             coreClkEn,
    output logic             sleeping,
    output logic             intAck,
    output logic [2:0]       intAckLevel,
    output logic [23:0]      busAddr,
    output logic             busStrobe,
    output logic             busWrite,
    input  wire logic        busAck,
    input  wire logic [15:0] dataLanesIn,
    output logic [15:0]      dataLanesOut,
    output logic             dataLanesOe,
    output logic             busOutOe,
    input  wire logic        busRequestIn,
    output logic             busGrantOut,
    input  wire logic [2:0]  interruptLevelLines,
    input  wire logic        restartReq
);
    lpc_pkg::lpc_state_e state_q;
    logic                strapTaken_q;
    logic                narrow_q;
    logic                beat_q;
    logic                xferHalt_q;
    logic                write_q;
    logic [23:0]         addr_q;
    logic [15:0]         wdata_q;
    logic [15:0]         rdata_q;
    logic [15:0]         status_q;
    logic                done_q;
    logic                ack_q;
    logic [2:0]          ackLevel_q;
    logic                startXfer;
    logic                lastBeat;
    logic [15:0]         fetched;
    logic [2:0]          mask;
    logic                qualifies;

    lpc_arb_if arb ();

    lpc_arbiter u_arbiter (
        .clk   (clk),
        .rst_b (rst_b),
        .arb   (arb)
    );

    assign arb.busRequest = busRequestIn;
    assign arb.busIdle    = (state_q != lpc_pkg::LPC_XFER) && !startXfer;

    // Strap sampled once after reset release and then frozen
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            strapTaken_q <= 1'b0;
            narrow_q     <= 1'b0;
        end
        else if (!strapTaken_q)
        begin
            strapTaken_q <= 1'b1;
            narrow_q     <= !widthSel16;
        end
    end

    // No bus cycle may start while another master owns the bus
    assign opReady   = (state_q == lpc_pkg::LPC_IDLE) && strapTaken_q && !arb.grant;
    assign startXfer = opReady && (haltReq || opReq);
    assign lastBeat  = !narrow_q || beat_q;

    // Assemble the word as it arrives; high byte comes first in narrow width
    always_comb
    begin
        fetched = rdata_q;
        if (!narrow_q)
            fetched = dataLanesIn;
        else if (!beat_q)
            fetched[15:8] = dataLanesIn[7:0];
        else
            fetched[7:0] = dataLanesIn[7:0];
    end

    assign mask      = status_q[lpc_pkg::SW_MASK_LSB +: 3];
    assign qualifies = (interruptLevelLines == lpc_pkg::LEVEL_NMI)
                     || (interruptLevelLines > mask);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            state_q <= lpc_pkg::LPC_IDLE;
        else
        begin
            unique case (state_q)
                lpc_pkg::LPC_IDLE:
                    if (startXfer)
                        state_q <= lpc_pkg::LPC_XFER;
                lpc_pkg::LPC_XFER:
                    if (busAck && lastBeat)
                        state_q <= xferHalt_q ? lpc_pkg::LPC_SLEEP : lpc_pkg::LPC_IDLE;
                lpc_pkg::LPC_SLEEP:
                    if (restartReq)
                        state_q <= lpc_pkg::LPC_WOKEN;
                lpc_pkg::LPC_WOKEN:
                    if (qualifies)
                        state_q <= lpc_pkg::LPC_RELEASE;
                lpc_pkg::LPC_RELEASE:
                    if (!arb.grant)
                        state_q <= lpc_pkg::LPC_IDLE;
                // Three unused codes of the state register fall back to idle
                default:
                    state_q <= lpc_pkg::LPC_IDLE;
            endcase
        end
    end

    // Transfer address, data and beat tracking
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            beat_q     <= 1'b0;
            xferHalt_q <= 1'b0;
            write_q    <= 1'b0;
            addr_q     <= '0;
            wdata_q    <= '0;
            rdata_q    <= '0;
        end
        else if (startXfer)
        begin
            beat_q     <= 1'b0;
            xferHalt_q <= haltReq;
            write_q    <= opWrite && !haltReq;
            addr_q     <= opAddr;
            wdata_q    <= opWdata;
        end
        else if (state_q == lpc_pkg::LPC_XFER && busAck)
        begin
            rdata_q <= fetched;
            if (!lastBeat)
            begin
                beat_q <= 1'b1;
                addr_q <= addr_q + lpc_pkg::BYTE_STEP;
            end
        end
    end

    // Halt operand becomes the status word the moment the fetch ends
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            status_q <= lpc_pkg::SW_RESET;
        else if (state_q == lpc_pkg::LPC_XFER && busAck && lastBeat && xferHalt_q)
            status_q <= fetched;
    end

    // Completion pulse for ordinary transfers and for the end of a halt
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            done_q <= 1'b0;
        else
            done_q <= (state_q == lpc_pkg::LPC_XFER && busAck && lastBeat && !xferHalt_q)
                   || (state_q == lpc_pkg::LPC_RELEASE && !arb.grant);
    end

    // Recognised interrupt, reported once on wake
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ack_q      <= 1'b0;
            ackLevel_q <= '0;
        end
        else
        begin
            ack_q <= (state_q == lpc_pkg::LPC_WOKEN) && qualifies;
            if ((state_q == lpc_pkg::LPC_WOKEN) && qualifies)
                ackLevel_q <= interruptLevelLines;
        end
    end

    // Narrow writes put each byte on the low lanes; upper lanes idle at a fixed value
    always_comb
    begin
        if (!narrow_q)
            dataLanesOut = wdata_q;
        else if (!beat_q)
            dataLanesOut = {lpc_pkg::LANE_FILL, wdata_q[15:8]};
        else
            dataLanesOut = {lpc_pkg::LANE_FILL, wdata_q[7:0]};
    end

    // Clock stays gated from sleep entry until a resume request
    assign coreClkEn   = (state_q != lpc_pkg::LPC_SLEEP);
    assign sleeping    = (state_q == lpc_pkg::LPC_SLEEP) || (state_q == lpc_pkg::LPC_WOKEN);
    assign busGrantOut = arb.grant;
    assign busOutOe    = !arb.grant;
    assign busStrobe   = (state_q == lpc_pkg::LPC_XFER);
    assign busWrite    = busStrobe && write_q;
    assign dataLanesOe = busWrite && busOutOe;
    assign busAddr     = addr_q;
    assign opRdata     = rdata_q;
    assign statusWord  = status_q;
    assign opDone      = done_q;
    assign intAck      = ack_q;
    assign intAckLevel = ackLevel_q;

    chk_width_static: assert property (@(posedge clk) disable iff (!rst_b)
        strapTaken_q |=> $stable(narrow_q) && strapTaken_q)
        else $error("data width changed during operation");

    chk_upper_lanes: assert property (@(posedge clk) disable iff (!rst_b)
        narrow_q && dataLanesOe |-> dataLanesOut[15:8] == lpc_pkg::LANE_FILL)
        else $error("upper lanes carry data in narrow width");

    chk_narrow_beats: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_XFER) && narrow_q && !beat_q && busAck
        |=> (state_q == lpc_pkg::LPC_XFER) && beat_q
            && busAddr == $past(busAddr) + lpc_pkg::BYTE_STEP)
        else $error("narrow operand fetch did not take a second cycle");

    chk_wide_single: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_XFER) && !narrow_q && xferHalt_q && busAck
        |=> (state_q == lpc_pkg::LPC_SLEEP) && !coreClkEn)
        else $error("wide operand fetch took more than one cycle");

    chk_status_load: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_XFER) && xferHalt_q && busAck && lastBeat
        |=> statusWord == $past(fetched) && sleeping)
        else $error("halt operand not loaded into status word");

    chk_stay_asleep: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_WOKEN) && !qualifies |=> sleeping && !opDone)
        else $error("left low power without a qualifying interrupt");

    chk_clock_resume: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_SLEEP) && restartReq |-> !coreClkEn ##1 coreClkEn)
        else $error("clock did not resume on the next edge");

    chk_wake_ack: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_WOKEN) && qualifies
        |=> intAck && intAckLevel == $past(interruptLevelLines) && !sleeping)
        else $error("qualifying interrupt not recognised");

    chk_hold_floated: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpc_pkg::LPC_RELEASE) && busGrantOut |=> !opDone && !opReady)
        else $error("resumed while bus still granted away");
endmodule

// [tb/lpc_glue_model.sv]
// Glue logic model: bus memory answering transfers and clock restart control
`timescale 1ns/1ps
module lpc_glue_model (
    input  wire logic        clk,
    input  wire logic        busStrobe,
    input  wire logic [23:0] busAddr,
    input  wire logic        coreClkEn,
    input  wire logic        sleeping,
    input  wire logic        wakeEn,
    input  wire logic [1:0]  ackDelay,
    output logic             busAck,
    output logic [15:0]      dataLanesIn,
    output logic             restartReq
);
    logic [1:0]  waitQ;
    logic [2:0]  settleQ;
    logic [15:0] lastQ;

    initial
    begin
        busAck = 1'b0;
        restartReq = 1'b0;
        waitQ = 2'h0;
        settleQ = 3'h0;
        lastQ = 16'h0000;
    end

    // Lanes carry a pattern only in the ack cycle, then an inverted stale value
    assign dataLanesIn = busAck ? {~busAddr[7:0], busAddr[7:0]} : ~lastQ;

    always @(posedge clk)
    begin
        if (busAck)
            lastQ <= dataLanesIn;
        if (busStrobe && !busAck && waitQ == ackDelay)
        begin
            busAck <= 1'b1;
            waitQ <= 2'h0;
        end
        else
        begin
            busAck <= 1'b0;
            if (busStrobe && !busAck)
                waitQ <= waitQ + 2'h1;
        end
    end

    // Clock never gated here, so no runt pulses reach the core
    // Restart only after the core clock has been stopped a few cycles
    always @(posedge clk)
    begin
        if (coreClkEn || !wakeEn || !sleeping)
        begin
            settleQ <= 3'h0;
            restartReq <= 1'b0;
        end
        else if (settleQ == 3'h3)
            restartReq <= 1'b1;
        else
            settleQ <= settleQ + 3'h1;
    end
endmodule

// [tb/tb_cpu_low_power_clock_stop_wake.sv]
// Self-checking bench for the clock stop and wake block
`timescale 1ns/1ps
module tb_cpu_low_power_clock_stop_wake;
    logic clk = 0, rst_b = 0, widthSel16 = 1, opReq = 0, opWrite = 0, haltReq = 0;
    logic busRequestIn = 0, wakeEn = 0, opReady, opDone, coreClkEn, sleeping, intAck;
    logic busStrobe, busWrite, busAck, dataLanesOe, busOutOe, busGrantOut, restartReq;
    logic [23:0] opAddr = 0, busAddr, lastAddr = 0;
    logic [15:0] opWdata = 0, opRdata, statusWord, dataLanesIn, dataLanesOut;
    logic [2:0]  intAckLevel, interruptLevelLines = 0;
    logic [1:0]  ackDelay = 0;
    logic [31:0] wrLog = 0;
    int          numErrors = 0, checkCount = 0, ackCnt = 0, a0;

    lpc_clock_stop dut (.clk(clk), .rst_b(rst_b), .widthSel16(widthSel16), .opReq(opReq),
        .opWrite(opWrite), .opAddr(opAddr), .opWdata(opWdata), .haltReq(haltReq),
        .opReady(opReady), .opDone(opDone), .opRdata(opRdata), .statusWord(statusWord),
        .coreClkEn(coreClkEn), .sleeping(sleeping), .intAck(intAck),
        .intAckLevel(intAckLevel), .busAddr(busAddr), .busStrobe(busStrobe),
        .busWrite(busWrite), .busAck(busAck), .dataLanesIn(dataLanesIn),
        .dataLanesOut(dataLanesOut), .dataLanesOe(dataLanesOe), .busOutOe(busOutOe),
        .busRequestIn(busRequestIn), .busGrantOut(busGrantOut),
        .interruptLevelLines(interruptLevelLines), .restartReq(restartReq));
    lpc_glue_model glue (.clk(clk), .busStrobe(busStrobe), .busAddr(busAddr),
        .coreClkEn(coreClkEn), .sleeping(sleeping), .wakeEn(wakeEn), .ackDelay(ackDelay),
        .busAck(busAck), .dataLanesIn(dataLanesIn), .restartReq(restartReq));

    always #2 clk = ~clk;

    // Beat counter and write-lane log, sampled at the ack edge
    always @(posedge clk)
    begin
        if (busAck)
            ackCnt <= ackCnt + 1;
        if (busAck)
            lastAddr <= busAddr;
        // Lanes only count as written while the core drives them
        if (busAck && busWrite && dataLanesOe)
            wrLog <= {wrLog[15:0], dataLanesOut};
    end

    task automatic reportAndStop();
        $display("checks %0d errors %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic hit(input int sel);
        case (sel)
            0: return opDone;
            1: return !coreClkEn;
            2: return restartReq;
            3: return intAck;
            4: return busGrantOut;
            default: return !busGrantOut;
        endcase
    endfunction

    // Bounded wait at falling edges; running out ends the run
    task automatic waitFor(input int sel);
        for (int i = 0; i < 80 && hit(sel) !== 1'b1; i++)
            @(negedge clk);
        if (hit(sel) !== 1'b1)
        begin
            numErrors++;
            $display("[ERR] %0t wait ran out, case %0d", $time, sel);
            reportAndStop();
        end
    endtask

    task automatic doOp(input logic wr, input logic hlt, input logic [23:0] a,
                        input logic [15:0] d);
        for (int i = 0; i < 20 && opReady !== 1'b1; i++)
            @(negedge clk);
        if (opReady !== 1'b1)
        begin
            numErrors++;
            $display("[ERR] %0t request never taken", $time);
            reportAndStop();
        end
        a0 = ackCnt;
        opReq = !hlt;
        haltReq = hlt;
        opWrite = wr;
        opAddr = a;
        opWdata = d;
        @(negedge clk);
        opReq = 0;
        haltReq = 0;
        if (!hlt)
            waitFor(0);
    endtask

    task automatic doReset(input logic w16);
        rst_b = 0;
        widthSel16 = w16;
        repeat (4) @(negedge clk);
        check(statusWord, 16'h2700);
        check({busGrantOut, coreClkEn, busOutOe}, 3'h3);
        rst_b = 1;
        repeat (2) @(negedge clk);
    endtask

    task automatic wideTransfers();
        for (int dly = 0; dly < 3; dly++)
        begin
            ackDelay = dly[1:0];
            doOp(0, 0, 24'h000A5C, 16'h0000);
            check(opRdata, 16'hA35C);
            check(ackCnt - a0, 1);
        end
        doOp(1, 0, 24'h001234, 16'hA55A);
        check(wrLog[15:0], 16'hA55A);
    endtask

    task automatic sleepAndWake16();
        doOp(1, 0, 24'h00FFFE, 16'h0000);
        doOp(0, 1, 24'h0000DF, 16'h0000);
        waitFor(1);
        check(ackCnt - a0, 1);
        check({statusWord, sleeping}, {16'h20DF, 1'b1});
        wakeEn = 1;
        waitFor(2);
        check(coreClkEn, 1'b0);
        @(negedge clk);
        check(coreClkEn, 1'b1);
        repeat (6) @(negedge clk);
        check({sleeping, intAck}, 2'h2);
        interruptLevelLines = 3'h3;
        waitFor(3);
        check(intAckLevel, 3'h3);
        waitFor(0);
        wakeEn = 0;
        interruptLevelLines = 3'h0;
    endtask

    task automatic idleArbitration();
        busRequestIn = 1;
        waitFor(4);
        check({opReady, busOutOe}, 2'h0);
        busRequestIn = 0;
        waitFor(5);
    endtask

    task automatic narrowAndFloat();
        doReset(0);
        doOp(0, 0, 24'h000340, 16'h0000);
        check(opRdata, 16'h4041);
        check(ackCnt - a0, 2);
        check(lastAddr, 24'h000341);
        doOp(1, 0, 24'h000010, 16'hBEEF);
        check(wrLog, 32'h00BE00EF);
        doOp(0, 1, 24'h0000F8, 16'h0000);
        busRequestIn = 1;
        waitFor(1);
        check(ackCnt - a0, 2);
        check(statusWord, 16'hF8F9);
        waitFor(4);
        check(busOutOe, 1'b0);
        interruptLevelLines = 3'h7;
        wakeEn = 1;
        waitFor(3);
        check(intAckLevel, 3'h7);
        repeat (4)
        begin
            @(negedge clk);
            check(opDone, 1'b0);
        end
        busRequestIn = 0;
        waitFor(0);
        wakeEn = 0;
    endtask

    initial
    begin
        doReset(1);
        wideTransfers();
        sleepAndWake16();
        idleArbitration();
        narrowAndFloat();
        reportAndStop();
    end
endmodule
